// ===== pkg/strc_pkg.sv
package strc_pkg;

  // Memory clock frequency and derived trigger interval
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TRIG_PERIOD_US = 24;
  localparam int unsigned TRIG_CYCLES = TRIG_PERIOD_US * CLK_MHZ;
  localparam int unsigned TRIG_CNT_W = 13;

  // Refresh deadline: the whole raster within one tenth of a second
  localparam int unsigned REFRESH_LIMIT_MS = 100;

  // Address and word geometry
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned WORD_W = 40;
  localparam int unsigned NUM_ADDR = 1 << ADDR_W;

  // Pulse chain phase lengths in clock cycles
  localparam int unsigned PH_W = 10;
  localparam logic [PH_W-1:0] DOT_CYC = 10'h028;
  localparam logic [PH_W-1:0] TEST_CYC = 10'h014;
  localparam logic [PH_W-1:0] DASH_CYC = 10'h050;
  localparam logic [PH_W-1:0] DONE_CYC = 10'h00A;

  // Reset values
  localparam logic [ADDR_W-1:0] DISP_RST = 10'h000;
  localparam logic [TRIG_CNT_W-1:0] TRIG_RST = 13'h0000;

  // Pulse chain states, one-hot
  typedef enum logic [4:0] {
    STRC_IDLE = 5'h01,
    STRC_DOT = 5'h02,
    STRC_TEST = 5'h04,
    STRC_DASH = 5'h08,
    STRC_DONE = 5'h10
  } strc_state_t;

  // Access request from the order/control side
  typedef struct packed {
    logic act;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } strc_req_t;

  // Beam drive bundle toward deflection and grids
  typedef struct packed {
    logic [ADDR_W-1:0] pos;
    logic offset;
    logic [WORD_W-1:0] beam;
  } strc_beam_t;

endpackage : strc_pkg

// ===== rtl/strc_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// [RL1] Two cycle kinds: action and regenerate
// [RL2] Regenerate whenever no access is pending
// [RL3] Trigger every 24 us launches chain
// [RL4] Chain steps dispatch counter for position
// [RL5] Spots refreshed in address order
// [RL6] Each spot refreshed within a tenth second; code forces no regenerate, so back-to-back accesses can stall the sweep
// [RL7] Dot encodes one, dash encodes zero
// [RL8] Write select marks a write cycle
// [RL9] Regenerate and read share bit logic
// [RL10] Write select and regen/read mutually exclusive
// [RL11] Dot pulse turns beam on at position
// [RL12] Dash test gate samples sense into flipflop
// [RL13] Clamp positive dash excursion before gate
// [RL14] Set sense flipflop keeps beam on
// [RL15] Regenerate dash sets vertical offset flipflop
// [RL16] Clear sense turns beam off after dot
// [RL17] Position from order or counter, all tubes
// [RL18] Order on action, counter on regenerate
// [RL19] Write: zero holds beam, one drops it
// [RL20] Read data from sense flipflop zero side
// [RL21] Counter wraps, sweep repeats forever
module strc_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire strc_pkg::strc_req_t i_req,
  input wire logic [strc_pkg::WORD_W-1:0] i_sense,
  input wire logic [strc_pkg::WORD_W-1:0] i_sense_clamp,
  output logic o_trig,
  output logic o_write_sel,
  output logic o_regen_read,
  output logic o_action,
  output strc_pkg::strc_beam_t o_beam,
  output logic o_monitor_beam,
  output logic [strc_pkg::ADDR_W-1:0] o_dispatch,
  output logic o_ack,
  output logic [strc_pkg::WORD_W-1:0] o_rdata
);

  // Reset synchroniser: asynchronous assert, two-stage release
  // Release is synchronised so no flop leaves reset on a different edge
  // Assertion stays asynchronous so the block clears even without a clock
  logic rst_meta_reg; // First stage, may go metastable on release
  logic rst_sync_reg; // Second stage, the only one the logic reads
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rstn = rst_sync_reg;

  // Sense lines come from analog comparators, so they are synchronised
  // The two extra cycles of latency are absorbed by the 40-cycle dot phase ahead of the test phase
  // Only the second stage feeds the sample gate, never the first
  logic [strc_pkg::WORD_W-1:0] sense_meta_reg;
  logic [strc_pkg::WORD_W-1:0] sense_sync_reg;
  logic [strc_pkg::WORD_W-1:0] clamp_meta_reg;
  logic [strc_pkg::WORD_W-1:0] clamp_sync_reg;
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      sense_meta_reg <= '0;
      sense_sync_reg <= '0;
      clamp_meta_reg <= '0;
      clamp_sync_reg <= '0;
    end else begin
      sense_meta_reg <= i_sense;
      sense_sync_reg <= sense_meta_reg;
      clamp_meta_reg <= i_sense_clamp;
      clamp_sync_reg <= clamp_meta_reg;
    end
  end

  // Memory clock: free-running divider giving one trigger pulse
  // It never stops, so regeneration goes on during long arithmetic
  // The trigger is a one-cycle enable, not a second clock
  logic [strc_pkg::TRIG_CNT_W-1:0] trig_cnt_reg;
  logic [strc_pkg::TRIG_CNT_W-1:0] trig_cnt_next;
  logic trig_reg;
  logic trig_next;
  always_comb begin
    if (trig_cnt_reg == strc_pkg::TRIG_CNT_W'(strc_pkg::TRIG_CYCLES - 1)) begin
      trig_cnt_next = strc_pkg::TRIG_RST;
      trig_next = 1'b1; // [RL3]
    end else begin
      trig_cnt_next = trig_cnt_reg + 1'b1;
      trig_next = 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      trig_cnt_reg <= strc_pkg::TRIG_RST;
      trig_reg <= 1'b0;
    end else begin
      trig_cnt_reg <= trig_cnt_next;
      trig_reg <= trig_next;
    end
  end

  // Pulse chain and per-cycle state
  // Cycle kind, write select, position and write word are latched at the trigger and held for the cycle,
  // so the order side may change its request once the ack is seen
  strc_pkg::strc_state_t state_reg; // Current chain phase
  strc_pkg::strc_state_t state_next; // Next chain phase
  logic [strc_pkg::PH_W-1:0] ph_reg; // Cycles spent in current phase
  logic [strc_pkg::PH_W-1:0] ph_next;
  logic action_reg; // Cycle kind latched at trigger
  logic action_next;
  logic wr_reg; // Write select for this cycle
  logic wr_next;
  // Beam position shared by all bit tubes and the monitor tube
  logic [strc_pkg::ADDR_W-1:0] pos_reg;
  logic [strc_pkg::ADDR_W-1:0] pos_next;
  // Accumulator word captured at the trigger for a write cycle
  logic [strc_pkg::WORD_W-1:0] wdata_reg;
  logic [strc_pkg::WORD_W-1:0] wdata_next;
  logic [strc_pkg::WORD_W-1:0] ff_reg; // Per-bit sense flipflops
  logic [strc_pkg::WORD_W-1:0] ff_next;
  // Per-tube beam enables, one bit per stored bit
  logic [strc_pkg::WORD_W-1:0] beam_reg;
  logic [strc_pkg::WORD_W-1:0] beam_next;
  logic offset_reg; // Vertical dash offset flipflop
  logic offset_next;
  logic [strc_pkg::ADDR_W-1:0] disp_reg; // Dispatch counter
  logic [strc_pkg::ADDR_W-1:0] disp_next;
  // One-cycle completion pulse of an action cycle
  logic ack_reg;
  logic ack_next;
  // Read word, held until the next action cycle ends
  logic [strc_pkg::WORD_W-1:0] rdata_reg;
  logic [strc_pkg::WORD_W-1:0] rdata_next;
  // Monitor tube follows the dot only, for viewing the raster
  logic mon_reg;
  logic mon_next;
  // Clamped sense, the input of the dash test gate
  logic [strc_pkg::WORD_W-1:0] gated;

  // Clamp limits the positive dash excursion, then test gate samples
  assign gated = sense_sync_reg & clamp_sync_reg; // [RL13]

  // Chain sequencing: dot, dash test, dash, done
  // All but the phase count and the ack hold by default; each phase changes only what it owns
  // A trigger that arrives while a chain runs is ignored; the chain is
  // much shorter than the trigger period, so this cannot happen in use
  always_comb begin
    state_next = state_reg;
    ph_next = ph_reg + 1'b1;
    action_next = action_reg;
    wr_next = wr_reg;
    pos_next = pos_reg;
    wdata_next = wdata_reg;
    ff_next = ff_reg;
    beam_next = beam_reg;
    offset_next = offset_reg;
    disp_next = disp_reg;
    ack_next = 1'b0;
    rdata_next = rdata_reg;
    mon_next = mon_reg;
    unique case (state_reg)
      strc_pkg::STRC_IDLE: begin
        ph_next = '0;
        if (trig_reg) begin // [RL3]
          state_next = strc_pkg::STRC_DOT;
          // An access takes the cycle; otherwise regenerate
          action_next = i_req.act; // [RL1] [RL2]
          wr_next = i_req.act & i_req.wr; // [RL8]
          wdata_next = i_req.wdata;
          // Order address on action, dispatch counter on regenerate
          pos_next = i_req.act ? i_req.addr : disp_reg; // [RL17] [RL18]
          ff_next = '0;
          offset_next = 1'b0;
          beam_next = {strc_pkg::WORD_W{1'b1}}; // [RL11]
          mon_next = 1'b1;
        end
      end
      // Beam on at the dot; sense settles through the synchroniser
      strc_pkg::STRC_DOT: begin
        if (ph_reg == strc_pkg::DOT_CYC - 1'b1) begin
          state_next = strc_pkg::STRC_TEST;
          ph_next = '0;
        end
      end
      // Dash test gate open: any dash signal sets the bit's flipflop
      // Flipflops only set here and clear at cycle start, so no clash
      strc_pkg::STRC_TEST: begin
        // Sampling runs on reads and writes alike for uniformity
        ff_next = ff_reg | gated; // [RL12] [RL9]
        if (ph_reg == strc_pkg::TEST_CYC - 1'b1) begin
          state_next = strc_pkg::STRC_DASH;
          ph_next = '0;
          offset_next = 1'b1; // [RL15]
          // Dot ends: beam stays only where a zero is kept
          if (wr_reg) begin
            beam_next = ~wdata_reg; // [RL19] [RL7]
          end else begin
            beam_next = ff_reg | gated; // [RL14] [RL16] [RL7]
          end
          mon_next = 1'b0;
        end
      end
      // Beam moved to the dash spot; lit bits discharge the dot
      strc_pkg::STRC_DASH: begin
        if (ph_reg == strc_pkg::DASH_CYC - 1'b1) begin
          state_next = strc_pkg::STRC_DONE;
          ph_next = '0;
          beam_next = '0;
          offset_next = 1'b0;
        end
      end
      // Settling time before the next trigger; results handed over here
      strc_pkg::STRC_DONE: begin
        if (ph_reg == strc_pkg::DONE_CYC - 1'b1) begin
          state_next = strc_pkg::STRC_IDLE;
          ph_next = '0;
          if (action_reg) begin
            ack_next = 1'b1;
            rdata_next = ~ff_reg; // [RL20]
          end else begin
            // Wraps naturally, so the sweep repeats for ever
            disp_next = disp_reg + 1'b1; // [RL4] [RL5] [RL21] [RL6]
          end
        end
      end
      // Illegal one-hot codes fall back to idle and wait for a trigger
      default: begin
        state_next = strc_pkg::STRC_IDLE;
        ph_next = '0;
      end
    endcase
  end

  // Register the chain state
  // Reset leaves the beam dark and the counter at the first address
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= strc_pkg::STRC_IDLE;
      ph_reg <= '0;
      action_reg <= 1'b0;
      wr_reg <= 1'b0;
      pos_reg <= strc_pkg::DISP_RST;
      wdata_reg <= '0;
      ff_reg <= '0;
      beam_reg <= '0;
      offset_reg <= 1'b0;
      disp_reg <= strc_pkg::DISP_RST;
      ack_reg <= 1'b0;
      rdata_reg <= '0;
      mon_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ph_reg <= ph_next;
      action_reg <= action_next;
      wr_reg <= wr_next;
      pos_reg <= pos_next;
      wdata_reg <= wdata_next;
      ff_reg <= ff_next;
      beam_reg <= beam_next;
      offset_reg <= offset_next;
      disp_reg <= disp_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      mon_reg <= mon_next;
    end
  end

  // Outputs straight from flipflops; select lines complementary
  // Both selects derive from one flop, so they can never overlap
  // Read and regenerate share the same select, as the bit logic is shared
  assign o_trig = trig_reg;
  assign o_write_sel = wr_reg; // [RL10]
  assign o_regen_read = ~wr_reg; // [RL10]
  assign o_action = action_reg;
  assign o_beam = '{pos: pos_reg, offset: offset_reg, beam: beam_reg};
  assign o_monitor_beam = mon_reg;
  assign o_dispatch = disp_reg;
  assign o_ack = ack_reg;
  assign o_rdata = rdata_reg;

endmodule : strc_ctrl

// ===== dv/strc_ctrl_monitor.sv
`timescale 1ns/10ps
module strc_ctrl_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire strc_pkg::strc_req_t i_req,
  input wire logic o_trig,
  input wire logic o_write_sel,
  input wire logic o_regen_read,
  input wire logic o_action,
  input wire strc_pkg::strc_beam_t o_beam,
  input wire logic o_monitor_beam,
  input wire logic [strc_pkg::ADDR_W-1:0] o_dispatch,
  input wire logic o_ack
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic [12:0] cnt_reg; // Cycles since last trigger
  logic seen_reg; // First trigger seen, period now checkable
  // Count trigger spacing
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= 13'h0000;
      seen_reg <= 1'b0;
    end else begin
      cnt_reg <= o_trig ? 13'h0000 : cnt_reg + 13'h0001;
      seen_reg <= seen_reg | o_trig;
    end
  end
  a_sel_exclusive: assert property (o_write_sel != o_regen_read) else $error("select lines clash");
  a_trig_period: assert property (o_trig && seen_reg |-> cnt_reg == 13'(strc_pkg::TRIG_CYCLES - 1))
    else $error("trigger period wrong");
  a_dot_beam_on: assert property (o_trig |=> o_beam.beam == '1 && o_monitor_beam)
    else $error("beam not on at dot");
  a_action_ack: assert property (o_trig ##1 o_action |-> ##150 o_ack) else $error("ack late");
  a_regen_step: assert property (o_trig ##1 !o_action |-> ##150 (o_dispatch - $past(o_dispatch, 150)) == 10'h001)
    else $error("dispatch not advanced");
  a_order_pos: assert property (o_trig ##1 o_action |-> o_beam.pos == $past(i_req.addr))
    else $error("action position wrong");
  a_regen_pos: assert property (o_trig ##1 !o_action |-> o_beam.pos == o_dispatch)
    else $error("regen position wrong");
  a_write_zero: assert property ($rose(o_beam.offset) && o_write_sel |-> o_beam.beam == ~i_req.wdata)
    else $error("write dash beam wrong");
endmodule : strc_ctrl_monitor
bind strc_ctrl strc_ctrl_monitor mon (.i_clk_sys, .i_rstn, .i_req, .o_trig, .o_write_sel, .o_regen_read,
  .o_action, .o_beam, .o_monitor_beam, .o_dispatch, .o_ack);

// ===== dv/strc_tube_model.sv
`timescale 1ns/10ps
module strc_tube_model (
  input wire logic i_clk_sys,
  input wire strc_pkg::strc_beam_t i_beam,
  output logic [strc_pkg::WORD_W-1:0] o_sense,
  output logic [strc_pkg::WORD_W-1:0] o_clamp
);
  logic [strc_pkg::WORD_W-1:0] mem [strc_pkg::NUM_ADDR]; // One bit is a dot
  logic tgl = 1'b0; // Changing idle pattern, so stale sense is never mistaken for data
  initial foreach (mem[i]) mem[i] = '0;
  assign o_clamp = '1;
  // Dash position hit discharges the dot; dark beam keeps it
  always @(posedge i_clk_sys) begin
    tgl <= ~tgl;
    if (i_beam.offset) mem[i_beam.pos] <= ~i_beam.beam;
    o_sense <= (|i_beam.beam && !i_beam.offset) ? ~mem[i_beam.pos] : {20{tgl, ~tgl}};
  end
endmodule : strc_tube_model

// ===== dv/test_storage_tube_regen_control.sv
`timescale 1ns/10ps
module test_storage_tube_regen_control;
  logic i_clk_sys = 1'b0; // 5 ns clock
  logic i_rstn = 1'b0; // Held low at start
  strc_pkg::strc_req_t i_req = '0; // Order from control side
  logic [strc_pkg::WORD_W-1:0] i_sense, i_sense_clamp, o_rdata, rd;
  logic o_trig, o_write_sel, o_regen_read, o_action, o_monitor_beam, o_ack;
  strc_pkg::strc_beam_t o_beam;
  logic [strc_pkg::ADDR_W-1:0] o_dispatch;
  int fails = 0;
  int checks = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  strc_ctrl uut (.i_clk_sys, .i_rstn, .i_req, .i_sense, .i_sense_clamp, .o_trig, .o_write_sel,
    .o_regen_read, .o_action, .o_beam, .o_monitor_beam, .o_dispatch, .o_ack, .o_rdata);
  strc_tube_model tube (.i_clk_sys, .i_beam(o_beam), .o_sense(i_sense), .o_clamp(i_sense_clamp));
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // One action cycle; request held until the ack edge
  task automatic access(input logic wr, input logic [9:0] a, input logic [39:0] wd);
    int n;
    @(posedge i_clk_sys) i_req <= '{act: 1'b1, wr: wr, addr: a, wdata: wd};
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (o_ack !== 1'b1 && n < 6000);
    check("ack seen", 40'(n < 6000), 40'h1);
    rd = o_rdata;
    @(posedge i_clk_sys) i_req <= '0;
  endtask : access
  // Word table: low and top address, mixed patterns
  logic [9:0] ta [3] = '{10'h003, 10'h3FF, 10'h200};
  logic [39:0] td [3] = '{40'hF00FA55AC3, 40'hFFFFFFFFFF, 40'h0000000001};
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    check("regen_read", 40'(o_regen_read), 40'h1);
    check("dispatch", 40'(o_dispatch), 40'h0);
    // Idle: regenerate cycle steps the counter
    wait (o_trig === 1'b1);
    repeat (160) @(posedge i_clk_sys);
    check("dispatch", 40'(o_dispatch), 40'h1);
    check("action", 40'(o_action), 40'h0);
    // Address 0 was regenerated as zero
    access(1'b0, 10'h000, '0);
    check("regen word", rd, 40'h0);
    foreach (ta[i]) begin
      access(1'b1, ta[i], td[i]);
      check("write_sel", 40'(o_write_sel), 40'h1);
      access(1'b0, ta[i], '0);
      check("read word", rd, td[i]);
      check("read sel", 40'(o_regen_read), 40'h1);
    end
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    fails++;
    finish_test();
  end
endmodule : test_storage_tube_regen_control
